/* rtl/irq_status_pkg.sv */
// package: register map, field layout and reset values of the fault and pin-event flags
package irq_status_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] UV_FLAGS_IDX = 8'h1c;
  localparam logic [7:0] OC_FLAGS_IDX = 8'h1d;
  localparam logic [7:0] PIN_FLAGS_IDX = 8'h1e;
  localparam logic [7:0] UV_MASK_IDX = 8'h40;
  localparam logic [7:0] OC_MASK_IDX = 8'h41;
  localparam logic [7:0] PIN_MASK_IDX = 8'h42;
  localparam logic [7:0] PIN_TRIG_IDX = 8'h43;
  localparam logic [7:0] PIN_POL_IDX = 8'h44;
  localparam logic [7:0] PIN_BOTH_IDX = 8'h45;
  // field positions
  localparam int LINREG_LSB = 8;
  localparam int CONV_LSB = 0;
  localparam int OC_BIT = 15;
  localparam int NUM_PINS = 13;
  // reset values
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'hffff;
  localparam logic [15:0] TRIG_RESET = 16'h0000;
  localparam logic [15:0] POL_RESET = 16'h0000;
  localparam logic [15:0] BOTH_RESET = 16'h0000;
  // raw fault and pin levels into the block
  typedef struct packed {
    logic [3:0] linreg_uv;
    logic [3:0] conv_uv;
    logic limit_sw_oc;
    logic [12:0] pins;
  } fault_in_t;
  // per-pin trigger configuration
  typedef struct packed {
    logic [12:0] level_mode;
    logic [12:0] active_low;
    logic [12:0] both_edges;
  } pin_trig_t;
endpackage

/* rtl/pin_trigger.sv */
// pin_trigger: per-pin event detector with selectable edge or level trigger
`timescale 1ns/1ps
module pin_trigger (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [12:0] pin_sync,
  input wire irq_status_pkg::pin_trig_t cfg,
  output logic [12:0] pin_event
);
  import irq_status_pkg::*;
  logic [12:0] prev_reg;

  // previous sampled level for edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= pin_sync;
    end
  end

  // one detector per pin, mode chosen by that pin's configuration
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i = i + 1) begin : g_pin
      wire active_lvl = pin_sync[i] ^ cfg.active_low[i];
      wire prev_lvl = prev_reg[i] ^ cfg.active_low[i];
      wire edge_hit = cfg.both_edges[i] ? (pin_sync[i] ^ prev_reg[i])
                                        : (active_lvl & ~prev_lvl);
      assign pin_event[i] = cfg.level_mode[i] ? active_lvl : edge_hit;
    end
  endgenerate
endmodule

/* rtl/fault_and_gpio_irq_status.sv */
// fault_and_gpio_irq_status: read-clear fault and pin-event flags with masked interrupt over APB
//
// Overview of operation
// - undervoltage flags: regulators bits 11:8, converters 3:0
// - limit-switch overcurrent rising edge sets bit 15
// - one event flag per pin, bits 12:0
// - pin flag follows its configured trigger condition
// - reading register clears its flags; reset zero
// - mask bit 0 passes interrupt, 1 blocks
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module fault_and_gpio_irq_status (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire irq_status_pkg::fault_in_t fault_in,
  output logic irq
);
  import irq_status_pkg::*;

  fault_in_t sync1_reg, sync2_reg, prev_reg;
  logic [15:0] supply_undervoltage_flags_reg, supply_undervoltage_flags_next;
  logic [15:0] overcurrent_flags_reg, overcurrent_flags_next;
  logic [15:0] pin_event_flags_reg, pin_event_flags_next;
  logic [15:0] uv_mask_reg, oc_mask_reg, pin_mask_reg;
  logic [15:0] trig_reg, pol_reg, both_reg;
  logic [31:0] prdata_reg;
  logic [12:0] pin_event;
  pin_trig_t pin_cfg;

  // two-stage synchroniser for the asynchronous fault and pin levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= fault_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // apb decode: zero-wait access, word index is paddr[9:2]
  wire [7:0] idx = paddr[9:2];
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_uv = (idx == UV_FLAGS_IDX);
  wire hit_oc = (idx == OC_FLAGS_IDX);
  wire hit_pin = (idx == PIN_FLAGS_IDX);
  wire hit_uvm = (idx == UV_MASK_IDX);
  wire hit_ocm = (idx == OC_MASK_IDX);
  wire hit_pinm = (idx == PIN_MASK_IDX);
  wire hit_trig = (idx == PIN_TRIG_IDX);
  wire hit_pol = (idx == PIN_POL_IDX);
  wire hit_both = (idx == PIN_BOTH_IDX);
  wire mapped = hit_uv | hit_oc | hit_pin | hit_uvm | hit_ocm | hit_pinm
                | hit_trig | hit_pol | hit_both;
  wire misaligned = (paddr[1:0] != 2'b00) | (paddr[31:10] != 22'h0);
  wire bad = ~mapped | misaligned | (pwrite & (hit_uv | hit_oc | hit_pin));
  assign pready = 1'b1;
  assign pslverr = access & bad;

  // pin trigger configuration fields, one driver for the whole struct
  assign pin_cfg = '{level_mode: trig_reg[12:0], active_low: pol_reg[12:0],
                     both_edges: both_reg[12:0]};

  pin_trigger pin_trigger_inst (
    .clk(clk),
    .nrst(nrst),
    .pin_sync(sync2_reg.pins),
    .cfg(pin_cfg),
    .pin_event(pin_event)
  );

  // rising-edge detection of supply faults
  wire [3:0] linreg_rise = sync2_reg.linreg_uv & ~prev_reg.linreg_uv;
  wire [3:0] conv_rise = sync2_reg.conv_uv & ~prev_reg.conv_uv;
  wire oc_rise = sync2_reg.limit_sw_oc & ~prev_reg.limit_sw_oc;
  wire [15:0] uv_set = {4'h0, linreg_rise, 4'h0, conv_rise};
  wire [15:0] oc_set = {oc_rise, 15'h0000};
  wire [15:0] pin_set = {3'h0, pin_event};
  wire clr_uv = rd & ~misaligned & hit_uv;
  wire clr_oc = rd & ~misaligned & hit_oc;
  wire clr_pin = rd & ~misaligned & hit_pin;

  // a read clears only the bits it showed at setup, so an event that lands
  // on the setup edge is not wiped unseen; a new event always sets
  wire [15:0] uv_clr = clr_uv ? prdata_reg[15:0] : 16'h0000;
  wire [15:0] oc_clr = clr_oc ? prdata_reg[15:0] : 16'h0000;
  wire [15:0] pin_clr = clr_pin ? prdata_reg[15:0] : 16'h0000;
  assign supply_undervoltage_flags_next =
    (supply_undervoltage_flags_reg & ~uv_clr) | uv_set;
  assign overcurrent_flags_next =
    (overcurrent_flags_reg & ~oc_clr) | oc_set;
  assign pin_event_flags_next =
    (pin_event_flags_reg & ~pin_clr) | pin_set;

  // status flag registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_undervoltage_flags_reg <= FLAGS_RESET;
      overcurrent_flags_reg <= FLAGS_RESET;
      pin_event_flags_reg <= FLAGS_RESET;
    end else begin
      supply_undervoltage_flags_reg <= supply_undervoltage_flags_next;
      overcurrent_flags_reg <= overcurrent_flags_next;
      pin_event_flags_reg <= pin_event_flags_next;
    end
  end

  // writable mask and trigger configuration registers
  wire wr_ok = wr & ~misaligned;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uv_mask_reg <= MASK_RESET;
      oc_mask_reg <= MASK_RESET;
      pin_mask_reg <= MASK_RESET;
      trig_reg <= TRIG_RESET;
      pol_reg <= POL_RESET;
      both_reg <= BOTH_RESET;
    end else begin
      if (wr_ok & hit_uvm) uv_mask_reg <= pwdata[15:0];
      if (wr_ok & hit_ocm) oc_mask_reg <= pwdata[15:0];
      if (wr_ok & hit_pinm) pin_mask_reg <= pwdata[15:0];
      if (wr_ok & hit_trig) trig_reg <= pwdata[15:0];
      if (wr_ok & hit_pol) pol_reg <= pwdata[15:0];
      if (wr_ok & hit_both) both_reg <= pwdata[15:0];
    end
  end

  // read mux; reserved flag bits and bits 31:16 read zero, mask and trigger registers read back all 16 bits
  wire [15:0] uv_view = supply_undervoltage_flags_reg & 16'h0f0f;
  wire [15:0] oc_view = overcurrent_flags_reg & 16'h8000;
  wire [15:0] pin_view = pin_event_flags_reg & 16'h1fff;
  wire [15:0] rd_sel =
    ({16{hit_uv}} & uv_view) | ({16{hit_oc}} & oc_view) |
    ({16{hit_pin}} & pin_view) | ({16{hit_uvm}} & uv_mask_reg) |
    ({16{hit_ocm}} & oc_mask_reg) | ({16{hit_pinm}} & pin_mask_reg) |
    ({16{hit_trig}} & trig_reg) | ({16{hit_pol}} & pol_reg) |
    ({16{hit_both}} & both_reg);
  wire [31:0] rd_word = misaligned ? 32'h00000000 : {16'h0000, rd_sel};

  // read data captured during the setup phase, stable through access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_reg <= rd_word;
    end
  end
  assign prdata = prdata_reg;

  // masked interrupt: mask bit 0 lets the flag through
  wire irq_uv = |(uv_view & ~uv_mask_reg);
  wire irq_oc = |(oc_view & ~oc_mask_reg);
  wire irq_pin = |(pin_view & ~pin_mask_reg);
  assign irq = irq_uv | irq_oc | irq_pin;
endmodule

/* bench/irq_status_asserts.sv */
// checker: port-level properties of the flag registers and interrupt
`timescale 1ns/1ps
module irq_status_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire irq_status_pkg::fault_in_t fault_in,
  input wire logic irq
);
  import irq_status_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // read setups per flag register, and writes other than 16'hffff to 0x100-0x10f (the three masks and the trigger register)
  wire logic rd = psel && !penable && !pwrite && pready;
  wire logic rd_uv = rd && paddr == 32'h70;
  wire logic rd_oc = rd && paddr == 32'h74;
  wire logic rd_pin = rd && paddr == 32'h78;
  wire logic open_wr = psel && penable && pwrite && paddr[31:4] == 28'h10
                       && pwdata[15:0] != 16'hffff;
  logic opened_reg;
  // remembers that software has written a value other than 16'hffff to a mask or to the trigger register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) opened_reg <= 1'b0;
    else if (open_wr) opened_reg <= 1'b1;
  end
  property p_uv;
    $rose(fault_in.linreg_uv[3]) ##[4:8] rd_uv |=> prdata[11];
  endproperty
  a_uv: assert property (p_uv) else $error("uv flag lost");
  property p_oc;
    $rose(fault_in.limit_sw_oc) ##[4:8] rd_oc |=> prdata[15];
  endproperty
  a_oc: assert property (p_oc) else $error("oc flag lost");
  property p_pin;
    $rose(fault_in.pins[12]) ##[4:8] rd_pin |=> prdata[12];
  endproperty
  a_pin: assert property (p_pin) else $error("pin flag lost");
  property p_reread;
    $stable(fault_in)[*4] ##0 rd_uv ##1 $stable(fault_in)[*3] ##0 rd_uv |=> prdata == 32'h0;
  endproperty
  a_reread: assert property (p_reread) else $error("read did not clear");
  property p_wr_ro;
    psel && penable && pwrite && paddr == 32'h70 |-> pslverr;
  endproperty
  a_wr_ro: assert property (p_wr_ro) else $error("flag write accepted");
  property p_rst;
    $rose(nrst) |-> prdata == 32'h0 && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_masked;
    !opened_reg |-> !irq;
  endproperty
  a_masked: assert property (p_masked) else $error("masked irq seen");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase not answered");
  c_reread: cover property (rd_uv ##3 rd_uv);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule

/* bench/host_model.sv */
// host model: apb master issuing register transfers for the bench
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [31:0] paddr = 32'h0,
  output logic [31:0] pwdata = 32'h0
);
  // setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* bench/test_fault_and_gpio_irq_status.sv */
// testbench: flag latching, read clear, masking and pin trigger modes
`timescale 1ns/1ps
module test_fault_and_gpio_irq_status;
  import irq_status_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  fault_in_t fault_in = '0;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  fault_and_gpio_irq_status fault_and_gpio_irq_status_inst (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_in, .irq);
  host_model host_model_inst (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    host_model_inst.xfer(w, a, d, rd, err);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, exp);
  endtask
  // waits out the sync stages and edge register
  task automatic settle;
    repeat (5) @(negedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b1, 32'h70, 32'hffff);
    check("wr err", {31'h0, err}, 32'h1);
    bus(1'b0, 32'h200, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    rdc(32'h70, 32'h0);
    rdc(32'h74, 32'h0);
    rdc(32'h78, 32'h0);
    $display("reset test done");
    fault_in.linreg_uv <= 4'h8;
    fault_in.conv_uv <= 4'h1;
    fault_in.limit_sw_oc <= 1'b1;
    settle();
    rdc(32'h74, 32'h8000);
    rdc(32'h70, 32'h0801);
    rdc(32'h70, 32'h0);
    rdc(32'h74, 32'h0);
    $display("fault test done");
    fault_in.pins[12] <= 1'b1;
    settle();
    check("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, 32'h108, 32'hefff);
    @(negedge clk);
    check("irq", {31'h0, irq}, 32'h1);
    rdc(32'h78, 32'h1000);
    @(negedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    $display("mask test done");
    fault_in.pins[0] <= 1'b1;
    settle();
    rdc(32'h78, 32'h0001);
    bus(1'b1, 32'h110, 32'h0001);
    fault_in.pins[0] <= 1'b0;
    settle();
    rdc(32'h78, 32'h0001);
    fault_in.pins[0] <= 1'b1;
    settle();
    rdc(32'h78, 32'h0);
    $display("trigger test done");
    fault_in.conv_uv <= 4'h3;
    rdc(32'h70, 32'h0);
    rdc(32'h70, 32'h0002);
    // event lands on the setup edge: not shown, must survive the clear
    fault_in.conv_uv <= 4'h7;
    @(posedge clk);
    rdc(32'h70, 32'h0);
    rdc(32'h70, 32'h0004);
    $display("collision test done");
    // both-edge trigger on pin 1
    bus(1'b1, 32'h114, 32'h0002);
    fault_in.pins[1] <= 1'b1;
    settle();
    rdc(32'h78, 32'h0002);
    fault_in.pins[1] <= 1'b0;
    settle();
    rdc(32'h78, 32'h0002);
    // level trigger on pin 2 re-sets while active
    bus(1'b1, 32'h10c, 32'h0004);
    fault_in.pins[2] <= 1'b1;
    settle();
    rdc(32'h78, 32'h0004);
    rdc(32'h78, 32'h0004);
    fault_in.pins[2] <= 1'b0;
    settle();
    rdc(32'h78, 32'h0004);
    rdc(32'h78, 32'h0);
    $display("pin mode test done");
    // overcurrent interrupt through its own mask
    bus(1'b1, 32'h104, 32'h7fff);
    fault_in.limit_sw_oc <= 1'b0;
    settle();
    check("irq", {31'h0, irq}, 32'h0);
    @(posedge clk);
    fault_in.limit_sw_oc <= 1'b1;
    settle();
    check("irq", {31'h0, irq}, 32'h1);
    rdc(32'h74, 32'h8000);
    @(negedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    $display("overcurrent mask test done");
    // second reset in mid-run, with all inputs idle
    fault_in <= '0;
    settle();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(32'h70, 32'h0);
    rdc(32'h78, 32'h0);
    rdc(32'h104, 32'hffff);
    check("irq", {31'h0, irq}, 32'h0);
    $display("second reset test done");
    final_report();
  end
endmodule
bind fault_and_gpio_irq_status irq_status_asserts irq_status_asserts_inst (.clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_in, .irq);
